/* File: rtl/mfs_manual_feedrate.v */
/*
  Manual and dry-run feedrate selection with rapid override method
  select. Machine-side signals arrive as pins from the sequence
  program and are synchronised; file register values and a config bit
  are written over a plain register port on core_clk.
*/
// Local design decisions: the register offsets and the strobed register port.
`timescale 1ns/1ns
`include "mfs_defines.vh"

module mfs_manual_feedrate #(
  parameter FEED_W = 32
) (
  input  wire                      core_clk,
  input  wire                      reset,
  input  wire                      scanTick,
  input  wire                      jogMode,
  input  wire                      incrementalMode,
  input  wire                      refReturnMode,
  input  wire                      autoMode,
  input  wire                      cuttingFeed,
  input  wire                      rapidMotion,
  input  wire                      axisMoving,
  input  wire                      dryRunSwitch,
  input  wire                      rapidTraverseRequest,
  input  wire                      machineInch,
  input  wire                      inchMode,
  input  wire                      manualFeedMethodSelect,
  input  wire                      rapidOverrideMethodSelect,
  input  wire [4:0]                manualFeedCode,
  input  wire [1:0]                feedIncrementSelect,
  input  wire [1:0]                rapidOverrideCode,
  input  wire [`MFS_ADDR_W-1:0]    regAddr,
  input  wire [`MFS_DATA_W-1:0]    regWrData,
  input  wire                      regWrStrobe,
  input  wire                      regRdStrobe,
  output reg  [`MFS_DATA_W-1:0]    regRdData_reg,
  output reg  [FEED_W-1:0]         feedrate_reg,
  output reg                       manualFeedActive_reg,
  output reg  [`MFS_DATA_W-1:0]    rapidOverride_reg
);

  // --------------------------------------------------------------------
  // Pin synchronisers
  // --------------------------------------------------------------------
  localparam PIN_W = 23;

  wire [PIN_W-1:0] pinRaw;
  reg  [PIN_W-1:0] pinMeta_reg;
  reg  [PIN_W-1:0] pinSync_reg;
  reg              scanLast_reg;

  assign pinRaw = {scanTick, jogMode, incrementalMode, refReturnMode,
                   autoMode, cuttingFeed, rapidMotion, axisMoving,
                   dryRunSwitch, rapidTraverseRequest, machineInch,
                   inchMode, manualFeedMethodSelect,
                   rapidOverrideMethodSelect, manualFeedCode,
                   feedIncrementSelect, rapidOverrideCode};

  // Two flops per pin; only the second stage is read by logic
  always @(posedge core_clk or posedge reset) begin
    if (reset) begin
      pinMeta_reg  <= {PIN_W{1'b0}};
      pinSync_reg  <= {PIN_W{1'b0}};
      scanLast_reg <= 1'b0;
    end else begin
      pinMeta_reg  <= pinRaw;
      pinSync_reg  <= pinMeta_reg;
      scanLast_reg <= pinSync_reg[22];
    end
  end

  // Named views of the synchronised pins
  wire       sScan       = pinSync_reg[22];
  wire       sJog        = pinSync_reg[21];
  wire       sInc        = pinSync_reg[20];
  wire       sRef        = pinSync_reg[19];
  wire       sAuto       = pinSync_reg[18];
  wire       sCut        = pinSync_reg[17];
  wire       sRapid      = pinSync_reg[16];
  wire       sMoving     = pinSync_reg[15];
  wire       sDry        = pinSync_reg[14];
  wire       sRapidReq   = pinSync_reg[13];
  wire       sMachInch   = pinSync_reg[12];
  wire       sInchMode   = pinSync_reg[11];
  wire       sFeedMethod = pinSync_reg[10];
  wire       sRovMethod  = pinSync_reg[9];
  wire [4:0] sCode       = pinSync_reg[8:4];
  wire [1:0] sIncSel     = pinSync_reg[3:2];
  wire [1:0] sRovCode    = pinSync_reg[1:0];

  // One pulse per rising edge of the scan tick
  wire scanPulse = sScan & ~scanLast_reg;

  // --------------------------------------------------------------------
  // Code table
  // --------------------------------------------------------------------
  // Columns: metric machine metric (0.01 mm/min), metric machine inch
  // (0.001 in/min), inch machine metric, inch machine inch.
  function [83:0] codeRow;
    input [4:0] code;
    begin
      case (code)
        5'h1F: codeRow = {21'd0, 21'd0, 21'd0, 21'd0};
        5'h1E: codeRow = {21'd100, 21'd40, 21'd51, 21'd20};
        5'h1D: codeRow = {21'd140, 21'd54, 21'd71, 21'd28};
        5'h1C: codeRow = {21'd200, 21'd79, 21'd102, 21'd40};
        5'h1B: codeRow = {21'd270, 21'd106, 21'd137, 21'd54};
        5'h1A: codeRow = {21'd370, 21'd146, 21'd188, 21'd74};
        5'h19: codeRow = {21'd520, 21'd205, 21'd264, 21'd104};
        5'h18: codeRow = {21'd720, 21'd283, 21'd366, 21'd144};
        5'h17: codeRow = {21'd1000, 21'd394, 21'd508, 21'd200};
        5'h16: codeRow = {21'd1400, 21'd551, 21'd711, 21'd280};
        5'h15: codeRow = {21'd2000, 21'd787, 21'd1016, 21'd400};
        5'h14: codeRow = {21'd2700, 21'd1060, 21'd1372, 21'd540};
        5'h13: codeRow = {21'd3700, 21'd1460, 21'd1880, 21'd740};
        5'h12: codeRow = {21'd5200, 21'd2050, 21'd2642, 21'd1040};
        5'h11: codeRow = {21'd7200, 21'd2830, 21'd3658, 21'd1440};
        5'h10: codeRow = {21'd10000, 21'd3940, 21'd5080, 21'd2000};
        5'h0F: codeRow = {21'd14000, 21'd5510, 21'd7112, 21'd2800};
        5'h0E: codeRow = {21'd20000, 21'd7870, 21'd10160, 21'd4000};
        5'h0D: codeRow = {21'd27000, 21'd10600, 21'd13716, 21'd5400};
        5'h0C: codeRow = {21'd37000, 21'd14600, 21'd18796, 21'd7400};
        5'h0B: codeRow = {21'd52000, 21'd20500, 21'd26416, 21'd10400};
        5'h0A: codeRow = {21'd72000, 21'd28300, 21'd36576, 21'd14400};
        5'h09: codeRow = {21'd100000, 21'd39400, 21'd50800, 21'd20000};
        5'h08: codeRow = {21'd140000, 21'd55100, 21'd71120, 21'd28000};
        5'h07: codeRow = {21'd200000, 21'd78700, 21'd99060, 21'd39000};
        5'h06: codeRow = {21'd270000, 21'd106000, 21'd137160, 21'd54000};
        5'h05: codeRow = {21'd370000, 21'd146000, 21'd187960, 21'd74000};
        5'h04: codeRow = {21'd520000, 21'd205000, 21'd264160, 21'd104000};
        5'h03: codeRow = {21'd720000, 21'd283000, 21'd365760, 21'd144000};
        5'h02: codeRow = {21'd1000000, 21'd394000, 21'd508000, 21'd200000};
        5'h01: codeRow = {21'd1400000, 21'd551000, 21'd711200, 21'd280000};
        default: codeRow = {84{1'b0}};
      endcase
    end
  endfunction

  // --------------------------------------------------------------------
  // Register file
  // --------------------------------------------------------------------
  reg [`MFS_DATA_W-1:0] valueLow_reg;
  reg [`MFS_DATA_W-1:0] valueHigh_reg;
  reg [`MFS_DATA_W-1:0] rapidValue_reg;
  reg [`MFS_DATA_W-1:0] config_reg;
  reg                   jogHold_reg;
  reg [`MFS_DATA_W-1:0] rdData_next;

  // Software writes the binary feed value and the override value
  always @(posedge core_clk or posedge reset) begin
    if (reset) begin
      valueLow_reg   <= `MFS_RST_VALUE;
      valueHigh_reg  <= `MFS_RST_VALUE;
      rapidValue_reg <= `MFS_RST_RAPID_VALUE;
      config_reg     <= `MFS_RST_CONFIG;
    end else if (regWrStrobe) begin
      case (regAddr)
        `MFS_OFS_VALUE_LOW:   valueLow_reg   <= regWrData;
        `MFS_OFS_VALUE_HIGH:  valueHigh_reg  <= regWrData;
        `MFS_OFS_RAPID_VALUE: rapidValue_reg <= regWrData;
        `MFS_OFS_CONFIG:      config_reg     <= regWrData;
        default: ;
      endcase
    end
  end

  // Read mux; unmapped offsets read as zero
  always @* begin
    rdData_next = {`MFS_DATA_W{1'b0}};
    case (regAddr)
      `MFS_OFS_VALUE_LOW:   rdData_next = valueLow_reg;
      `MFS_OFS_VALUE_HIGH:  rdData_next = valueHigh_reg;
      `MFS_OFS_RAPID_VALUE: rdData_next = rapidValue_reg;
      `MFS_OFS_CONFIG:      rdData_next = config_reg;
      `MFS_OFS_FEED_LOW:    rdData_next = feedrate_reg[15:0];
      `MFS_OFS_FEED_HIGH:   rdData_next = feedrate_reg[31:16];
      `MFS_OFS_STATUS: begin
        rdData_next[`MFS_STS_ACTIVE]   = manualFeedActive_reg;
        rdData_next[`MFS_STS_JOG_HOLD] = jogHold_reg;
      end
      default: rdData_next = {`MFS_DATA_W{1'b0}};
    endcase
  end

  // Read data stands only in the cycle after the strobe
  always @(posedge core_clk or posedge reset) begin
    if (reset) begin
      regRdData_reg <= {`MFS_DATA_W{1'b0}};
    end else if (regRdStrobe) begin
      regRdData_reg <= rdData_next;
    end else begin
      regRdData_reg <= {`MFS_DATA_W{1'b0}};
    end
  end

  // --------------------------------------------------------------------
  // Feedrate selection
  // --------------------------------------------------------------------
  reg  [20:0]             heldCode_reg;
  reg  [20:0]             decoded;
  reg  [`MFS_SCALE_W-1:0] scale;
  reg  [`MFS_DATA_W-1:0]  rovCodeValue;
  wire [83:0]             row = codeRow(sCode);
  wire [31:0]             fileValue = {valueHigh_reg, valueLow_reg};
  wire [45:0]             fileProduct;
  wire [20:0]             codeRate;
  wire [FEED_W-1:0]       manualRate;
  wire                    codeApplies;
  wire                    incHold;

  // Column pick by machine unit and unit mode
  always @* begin
    case ({sMachInch, sInchMode})
      2'b00:   decoded = row[83:63];
      2'b01:   decoded = row[62:42];
      2'b10:   decoded = row[41:21];
      2'b11:   decoded = row[20:0];
      default: decoded = 21'd0;
    endcase
  end

  // Least increment; inch units are one decade finer
  always @* begin
    case (sIncSel)
      2'b00:   scale = `MFS_SCALE_00;
      2'b01:   scale = `MFS_SCALE_01;
      2'b10:   scale = `MFS_SCALE_10;
      2'b11:   scale = `MFS_SCALE_11;
      default: scale = `MFS_SCALE_11;
    endcase
  end

  // Rapid override code table
  always @* begin
    case (sRovCode)
      2'b00:   rovCodeValue = `MFS_ROV_CODE_00;
      2'b01:   rovCodeValue = `MFS_ROV_CODE_01;
      2'b10:   rovCodeValue = `MFS_ROV_CODE_10;
      2'b11:   rovCodeValue = `MFS_ROV_CODE_11;
      default: rovCodeValue = `MFS_ROV_CODE_00;
    endcase
  end

  assign fileProduct = sInchMode ? fileValue * scale * 4'hA
                                 : {14'h0000, fileValue} * scale;

  // Step decoded this scan, or the held step when the code is all low
  assign codeRate = (sCode != `MFS_CODE_HOLD) ? decoded
                                              : heldCode_reg;

  // Code value or scaled file value
  assign manualRate = sFeedMethod ? fileProduct[FEED_W-1:0]
                                  : {{(FEED_W-21){1'b0}}, codeRate};

  // Modes in which the manual rate governs the feed
  assign codeApplies = ~sRapidReq &
                       ((sJog | sInc | sRef) |
                        (sAuto & sCut & sDry) |
                        (sAuto & sRapid & sDry &
                         config_reg[`MFS_CFG_RAPID_DRY]));

  // Incremental motion in progress keeps its speed
  assign incHold = sInc & ~sJog & sMoving;

  // Held code value; all-low code keeps the last step
  always @(posedge core_clk or posedge reset) begin
    if (reset) begin
      heldCode_reg <= 21'd0;
    end else if (scanPulse && sCode != `MFS_CODE_HOLD) begin
      heldCode_reg <= decoded;
    end
  end

  // Outputs change once per scan from the sampled set
  always @(posedge core_clk or posedge reset) begin
    if (reset) begin
      feedrate_reg         <= `MFS_RST_FEED;
      manualFeedActive_reg <= 1'b0;
      rapidOverride_reg    <= `MFS_ROV_CODE_00;
      jogHold_reg          <= 1'b0;
    end else if (scanPulse) begin
      manualFeedActive_reg <= codeApplies;
      jogHold_reg          <= incHold & manualFeedActive_reg;
      rapidOverride_reg    <= sRovMethod ? rapidValue_reg
                                         : rovCodeValue;
      if (!codeApplies) begin
        feedrate_reg <= {FEED_W{1'b0}};
      end else if (!(incHold && manualFeedActive_reg)) begin
        feedrate_reg <= manualRate;
      end
    end
  end

endmodule

/* File: rtl/mfs_defines.vh */
/*
  Constants for the manual feedrate select block: register offsets,
  field positions, reset values and the rapid override code table.
  Assumes it is included by bare name from the design file.
*/
`ifndef MFS_DEFINES_VH
`define MFS_DEFINES_VH

// ----------------------------------------------------------------------
// Register offsets (word index on the plain register port)
// ----------------------------------------------------------------------
`define MFS_ADDR_W            3
`define MFS_OFS_VALUE_LOW     3'h0
`define MFS_OFS_VALUE_HIGH    3'h1
`define MFS_OFS_RAPID_VALUE   3'h2
`define MFS_OFS_CONFIG        3'h3
`define MFS_OFS_FEED_LOW      3'h4
`define MFS_OFS_FEED_HIGH     3'h5
`define MFS_OFS_STATUS        3'h6

// ----------------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------------
`define MFS_DATA_W            16
`define MFS_CFG_RAPID_DRY     0
`define MFS_STS_ACTIVE        0
`define MFS_STS_JOG_HOLD      1
`define MFS_RST_VALUE         16'h0000
`define MFS_RST_RAPID_VALUE   16'h0064
`define MFS_RST_CONFIG        16'h0000
`define MFS_RST_FEED          32'h0000_0000

// ----------------------------------------------------------------------
// Rapid override code table, percent
// ----------------------------------------------------------------------
`define MFS_ROV_CODE_00       16'h0064
`define MFS_ROV_CODE_01       16'h0032
`define MFS_ROV_CODE_10       16'h0019
`define MFS_ROV_CODE_11       16'h0001

// ----------------------------------------------------------------------
// File value scale per increment code, in output units (0.01 mm/min)
// ----------------------------------------------------------------------
`define MFS_SCALE_W           14
`define MFS_SCALE_00          14'h03E8
`define MFS_SCALE_01          14'h0064
`define MFS_SCALE_10          14'h000A
`define MFS_SCALE_11          14'h0001
`define MFS_CODE_HOLD         5'h00

`endif

/* File: bench/mfs_sva.sv */
/* Port checker for the manual feedrate block.
   Bound from the testbench top onto the design's own ports. */
`timescale 1ns/1ns
module mfs_sva #(
  parameter FEED_W = 32
) (
  input wire              core_clk,
  input wire              reset,
  input wire              scanTick,
  input wire              jogMode,
  input wire              incrementalMode,
  input wire              refReturnMode,
  input wire              autoMode,
  input wire              cuttingFeed,
  input wire              dryRunSwitch,
  input wire              rapidTraverseRequest,
  input wire              rapidOverrideMethodSelect,
  input wire [1:0]        rapidOverrideCode,
  input wire [2:0]        regAddr,
  input wire              regRdStrobe,
  input wire [15:0]       regRdData_reg,
  input wire [FEED_W-1:0] feedrate_reg,
  input wire              manualFeedActive_reg,
  input wire [15:0]       rapidOverride_reg
);
  // ----------------------------------------
  // Scan properties
  // ----------------------------------------
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (reset);

  // Condition held before, across and after one scan
  sequence s_scan(c);
    c [*4] ##1 ($rose(scanTick) && c) ##1 c [*5];
  endsequence

  a_rapid_code: assert property (
    s_scan(!rapidOverrideMethodSelect && rapidOverrideCode == 2'h1)
    |-> rapidOverride_reg == 16'h0032) else $error("rapid code 01 not 50");
  a_jog_active: assert property (
    s_scan(jogMode && !rapidTraverseRequest) |-> manualFeedActive_reg)
    else $error("jog scan not active");
  a_idle_no_feed: assert property (
    s_scan(!jogMode && !incrementalMode && !refReturnMode && !autoMode)
    |-> !manualFeedActive_reg && feedrate_reg == 0)
    else $error("feed without manual mode");
  a_rapid_req_off: assert property (
    s_scan(rapidTraverseRequest)
    |-> !manualFeedActive_reg && feedrate_reg == 0)
    else $error("feed during rapid request");
  a_dry_cut_active: assert property (
    s_scan(autoMode && cuttingFeed && dryRunSwitch && !rapidTraverseRequest)
    |-> manualFeedActive_reg) else $error("dry run cut not active");
  a_scan_only_update: assert property (
    $changed(feedrate_reg) || $changed(rapidOverride_reg) ||
    $changed(manualFeedActive_reg) |->
    ($past(scanTick, 2) || $past(scanTick, 3)) && !$past(scanTick, 5))
    else $error("output moved between scans");

  // ----------------------------------------
  // Register port properties
  // ----------------------------------------
  a_read_one_cycle: assert property (
    regRdData_reg != 16'h0 |-> $past(regRdStrobe))
    else $error("read data outside its cycle");
  a_read_unmapped: assert property (
    $past(regRdStrobe) && $past(regAddr) == 3'h7 |-> regRdData_reg == 16'h0)
    else $error("unmapped read not zero");
endmodule

/* File: bench/mfs_plc_model.sv */
/* Scan source standing in for the sequence program's scan.
   Assumes one core_clk; run high lets scans repeat. */
`timescale 1ns/1ns
module mfs_plc_model (
  input  wire core_clk,
  input  wire run,
  output reg  scanTick
);
  // ----------------------------------------
  // Scan cadence
  // ----------------------------------------
  reg [3:0] phase_reg = 4'h0;
  initial scanTick = 1'b0;
  // One scan every 16 cycles, high for four
  always @(posedge core_clk) begin
    phase_reg <= run ? phase_reg + 4'h1 : 4'h0;
    scanTick  <= run && phase_reg < 4'h4;
  end
endmodule

/* File: bench/manual_feedrate_select_tb_top.sv */
/* Testbench top: corner and random scans of the manual feedrate block.
   Assumes the scan source model and the bound port checker. */
`timescale 1ns/1ns
`include "mfs_defines.vh"
module manual_feedrate_select_tb_top;
  // ----------------------------------------
  // Stimulus, design and expectations
  // ----------------------------------------
  localparam [69:0] STEP = {10'h2D0, 10'h208, 10'h172, 10'h10E, 10'h0C8,
                            10'h08C, 10'h064};
  logic        core_clk = 1'b0, reset = 1'b1, plcRun = 1'b1;
  logic        regWrStrobe = 1'b0, regRdStrobe = 1'b0;
  logic [12:0] pv = 13'h0;
  logic [4:0]  code = 5'h0;
  logic [1:0]  isel = 2'h0, rovc = 2'h0;
  logic [2:0]  regAddr = 3'h0;
  logic [15:0] regWrData = 16'h0, d;
  logic [15:0] mir [0:3] = '{16'h0, 16'h0, 16'h64, 16'h0};
  logic [31:0] r;
  wire         scanTick, manualFeedActive_reg;
  wire [15:0]  regRdData_reg, rapidOverride_reg;
  wire [31:0]  feedrate_reg;
  integer      errTotal = 0, checkCount = 0, cyc = 0, i;
  integer      seed = 32'h325AB943;

  mfs_manual_feedrate DUT (.core_clk(core_clk), .reset(reset),
    .scanTick(scanTick), .jogMode(pv[12]), .incrementalMode(pv[11]),
    .refReturnMode(pv[10]), .autoMode(pv[9]), .cuttingFeed(pv[8]),
    .rapidMotion(pv[7]), .axisMoving(pv[6]), .dryRunSwitch(pv[5]),
    .rapidTraverseRequest(pv[4]), .machineInch(pv[3]), .inchMode(pv[2]),
    .manualFeedMethodSelect(pv[1]), .rapidOverrideMethodSelect(pv[0]),
    .manualFeedCode(code), .feedIncrementSelect(isel),
    .rapidOverrideCode(rovc), .regAddr(regAddr), .regWrData(regWrData),
    .regWrStrobe(regWrStrobe), .regRdStrobe(regRdStrobe),
    .regRdData_reg(regRdData_reg), .feedrate_reg(feedrate_reg),
    .manualFeedActive_reg(manualFeedActive_reg),
    .rapidOverride_reg(rapidOverride_reg));
  mfs_plc_model uPlc (.core_clk(core_clk), .run(plcRun),
                      .scanTick(scanTick));

  // Clock and hang guard
  always #50 core_clk = ~core_clk;
  always @(posedge core_clk) begin
    cyc = cyc + 1;
    if (cyc == 20000) begin
      errTotal = errTotal + 1;
      endSim;
    end
  end

  task endSim;
    $display("checks %0d errors %0d", checkCount, errTotal);
    if (errTotal == 0 && checkCount > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task chk(input [31:0] got, input [31:0] exp);
    checkCount = checkCount + 1;
    if (got !== exp) begin
      errTotal = errTotal + 1;
      $display("wrong value at %0t: got %0h want %0h", $time, got, exp);
    end
  endtask
  // Register port cycles, mirrored for expectations
  task wr(input [2:0] a, input [15:0] v);
    @(posedge core_clk);
    regWrStrobe <= 1'b1;
    regAddr     <= a;
    regWrData   <= v;
    if (a < 3'h4)
      mir[a] = v;
    @(posedge core_clk);
    regWrStrobe <= 1'b0;
  endtask
  task rd(input [2:0] a);
    @(posedge core_clk);
    regRdStrobe <= 1'b1;
    regAddr     <= a;
    @(posedge core_clk);
    regRdStrobe <= 1'b0;
    #1;
    d = regRdData_reg;
  endtask
  // Three scans settle the held code, then outputs are compared
  task run(input [31:0] e);
    repeat (3) @(posedge scanTick);
    repeat (6) @(posedge core_clk);
    #1;
    chk(feedrate_reg, e);
    chk(manualFeedActive_reg, app());
    chk(rapidOverride_reg, rov());
  endtask
  function app;
    app = !pv[4] && (pv[12] || pv[11] || pv[10] ||
      pv[9] && pv[5] && (pv[8] || pv[7] && mir[3][0]));
  endfunction
  function [31:0] rov;
    rov = pv[0] ? mir[2] : (rovc == 2'h0) ? 32'h64 : (rovc == 2'h1) ?
      32'h32 : (rovc == 2'h2) ? 32'h19 : 32'h1;
  endfunction
  function [31:0] expFeed;
    integer k;
    logic [4:0] n;
    n = ~code;
    expFeed = pv[1] ? {mir[1], mir[0]} : 32'h0;
    if (pv[1]) begin
      for (k = isel; k < 3 + pv[2]; k = k + 1)
        expFeed = expFeed * 32'hA;
    end else if (n != 5'h0) begin
      expFeed = STEP[((n - 5'h1) % 7) * 10 +: 10];
      for (k = 7; k < n; k = k + 7)
        expFeed = expFeed * 32'hA;
    end
    if (!app())
      expFeed = 32'h0;
  endfunction

  // Corner cases first, then random settings
  initial begin
    repeat (10) @(posedge core_clk);
    reset <= 1'b0;
    wr(3'h7, 16'hFFFF);
    for (i = 0; i < 8; i = i + 1) begin
      rd(i[2:0]);
      chk(d, (i == 2) ? 32'h64 : 32'h0);
    end
    @(posedge core_clk);
    pv <= 13'h1008;
    code <= 5'h02;
    run(32'h7C060);
    @(posedge core_clk);
    pv <= 13'h100C;
    code <= 5'h01;
    run(32'h445C0);
    @(posedge core_clk);
    pv <= 13'h1004;
    run(32'h86858);
    @(posedge core_clk);
    pv <= 13'h1000;
    run(32'h155CC0);
    @(posedge core_clk);
    code <= 5'h00;
    run(32'h155CC0);
    @(posedge core_clk);
    pv <= 13'h1010;
    run(32'h0);
    @(posedge core_clk);
    pv <= 13'h02A0;
    run(32'h0);
    wr(3'h3, 16'h0001);
    run(32'h155CC0);
    wr(3'h3, 16'h0000);
    @(posedge core_clk);
    // Scans pause across reset so no half-seen scan follows release
    reset <= 1'b1;
    plcRun <= 1'b0;
    pv <= 13'h1000;
    mir = '{16'h0, 16'h0, 16'h64, 16'h0};
    repeat (2) @(posedge core_clk);
    reset <= 1'b0;
    plcRun <= 1'b1;
    run(32'h0);
    @(posedge core_clk);
    pv <= 13'h0800;
    code <= 5'h10;
    run(32'h2710);
    @(posedge core_clk);
    pv <= 13'h0840;
    code <= 5'h01;
    run(32'h2710);
    @(posedge core_clk);
    pv <= 13'h1040;
    run(32'h155CC0);
    wr(3'h0, 16'h0003);
    @(posedge core_clk);
    pv <= 13'h1006;
    run(32'h7530);
    rd(3'h4);
    chk(d, 32'h7530);
    rd(3'h6);
    chk(d, 32'h1);
    for (i = 0; i < 40; i = i + 1) begin
      r = $random(seed);
      wr(3'h0, r[15:0]);
      wr(3'h1, r[31:16]);
      wr(3'h2, r[23:8]);
      wr(3'h3, {15'h0, r[3]});
      rd(3'h2);
      chk(d, mir[2]);
      r = $random(seed);
      @(posedge core_clk);
      pv <= r[12:0] & 13'h1FB3;
      code <= (r[17:13] == 5'h0) ? 5'h1F : r[17:13];
      isel <= r[19:18];
      rovc <= r[21:20];
      #1;
      run(expFeed());
    end
    endSim;
  end
endmodule

bind mfs_manual_feedrate mfs_sva #(.FEED_W(FEED_W)) uSva (
  .core_clk(core_clk), .reset(reset), .scanTick(scanTick),
  .jogMode(jogMode), .incrementalMode(incrementalMode),
  .refReturnMode(refReturnMode), .autoMode(autoMode),
  .cuttingFeed(cuttingFeed), .dryRunSwitch(dryRunSwitch),
  .rapidTraverseRequest(rapidTraverseRequest),
  .rapidOverrideMethodSelect(rapidOverrideMethodSelect),
  .rapidOverrideCode(rapidOverrideCode), .regAddr(regAddr),
  .regRdStrobe(regRdStrobe), .regRdData_reg(regRdData_reg),
  .feedrate_reg(feedrate_reg),
  .manualFeedActive_reg(manualFeedActive_reg),
  .rapidOverride_reg(rapidOverride_reg));
